// *** src/ssu_pkg.sv ***
// Constants, register layouts and helpers for the serial unit
package ssu_pkg;
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_CTRL0 = 3'h1;
  localparam logic [2:0] OFS_CTRL1 = 3'h2;
  localparam logic [2:0] OFS_RATE = 3'h3;
  localparam logic [2:0] OFS_TXBUF = 3'h4;
  localparam logic [2:0] OFS_RXBUF = 3'h5;
  localparam logic [2:0] OFS_CLKPIN = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_ASYNC = 2'h2;
  localparam logic [1:0] CLKPIN_ALT = 2'h2;
  localparam logic [4:0] PRE_LAST_DIV1 = 5'h00;
  localparam logic [4:0] PRE_LAST_DIV8 = 5'h07;
  localparam logic [4:0] PRE_LAST_DIV32 = 5'h1f;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] SYNC_LEN = 4'h8;
  localparam logic [3:0] SYNC_LAST = 4'h7;
  localparam logic [3:0] FULL_LEN = 4'h9;
  localparam logic [8:0] DUMMY_DATA = 9'h1ff;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam int ST_OVR = 0;
  localparam int ST_FER = 1;
  localparam int ST_PER = 2;
  localparam int ST_SUM = 3;
  localparam int ST_RXFULL = 4;
  localparam int C1_TBEMPTY = 1;
  localparam int C1_TXDONE = 3;

  typedef struct packed {
    logic [5:0] rsvH; logic openDrain; logic parOdd; logic parEn; logic stop2;
    logic [1:0] lenSel; logic extClk; logic rsvL; logic [1:0] mode;
  } ssu_mode_t;
  typedef struct packed {
    logic [7:0] rsvH; logic msbFirst; logic clkPol; logic rsv5; logic hsDis;
    logic rsv3; logic hsFn; logic [1:0] preSel;
  } ssu_ctrl0_t;
  typedef struct packed {
    logic [8:0] rsvH; logic invData; logic contRx; logic txCause; logic rsv3;
    logic rxEn; logic rsv1; logic txEn;
  } ssu_ctrl1_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ssu_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ssu_rx_state_t;

  function automatic logic [3:0] ssu_len(input logic [1:0] sel);
    return (sel == 2'h0) ? 4'h7 : (sel == 2'h1) ? 4'h8 : 4'h9;
  endfunction
  function automatic logic [4:0] ssu_pre_last(input logic [1:0] sel);
    return (sel == 2'h0) ? PRE_LAST_DIV1 : (sel == 2'h1) ? PRE_LAST_DIV8 : PRE_LAST_DIV32;
  endfunction
  function automatic logic [7:0] ssu_rev8(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    return r;
  endfunction
  // Parity bit that completes the character for the chosen sense
  function automatic logic ssu_parity(input logic [8:0] d, input logic [3:0] len,
                                      input logic odd);
    return (^(d & (DUMMY_DATA >> (FULL_LEN - len)))) ^ odd;
  endfunction
  function automatic logic [8:0] ssu_align(input logic [8:0] sh, input logic [3:0] len);
    return sh >> (FULL_LEN - len);
  endfunction
endpackage

// *** src/ssu_serial_unit.sv ***
// Dual-mode serial unit: clock-synchronous and asynchronous engines with registers
// Function
// - Data output idles high, or floats when open-drain, until a transfer starts.
// - Synchronous receive needs transmit enable set; dummy data shift out after a re-arming read.
// - Synchronous clock pin is output on internal clock unless the alternate pin is selected, input on external clock.
// - Flow pin is port when disabled, else clear-to-send input or request-to-send output.
// - Clock polarity bit picks the shift and sample edges of the transfer clock.
// - Bit order bit picks LSB first or MSB first for both directions in synchronous mode; asynchronous frames always go LSB first.
// - Transfer clock may go out on the alternate pin, internal clock only.
// - In continuous receive, reading the receive buffer re-arms reception.
// - Data logic bit inverts data on buffer write and on buffer read.
// - Asynchronous frame has one start bit and 7, 8 or 9 data bits.
// - Optional odd or even parity, then one or two stop bits.
// - Internal bit rate is prescaled clock over 16 times rate value plus one.
// - External bit rate is pin clock over 16(n+1); not on third channel.
// - Transmit starts only with enable set, buffer full or synchronous re-arm pending, and clear-to-send low.
// - Reception starts only with receive enable set and a detected start bit.
// - Transmit request at buffer-to-shift move, or at shift completion.
// - Receive request when a character moves into the receive buffer.
// - Overrun flagged when a new character arrives before the buffer is read.
// - Framing error flagged when a stop bit is missing.
// - Parity error flagged when ones count disagrees with selected parity.
// - Error sum flag is set while any overrun, framing or parity error stands.
// - On overrun the buffer is overwritten and no receive request is raised.
`timescale 1ns/1ps
`default_nettype none
module ssu_serial_unit
  import ssu_pkg::*;
#(
  parameter bit HAS_ALT_CLK = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [2:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Serial data pins
  input wire logic serialDataInPin,
  output logic serialDataOutPin,
  output logic serialDataOutOe,
  // Transfer clock pins
  input wire logic transferClockPinIn,
  output logic transferClockPinOut,
  output logic transferClockPinOe,
  output logic alternateClockOutPin,
  output logic alternateClockOutOe,
  // Flow-control pin
  input wire logic flowCtlIn,
  output logic flowCtlOut,
  output logic flowCtlOe,
  // Request pulses
  output logic txIrqPulse,
  output logic rxIrqPulse
);
  ssu_mode_t mode_q;
  ssu_ctrl0_t ctrl0_q;
  ssu_ctrl1_t ctrl1_q;
  logic [1:0] clkPin_q;
  logic [7:0] rate_q;
  logic [8:0] txBuf_q, rxBuf_q, txShift_q, rxShift_q;
  logic txBufEmpty_q, txDone_q, rxFull_q, ovr_q, fer_q, per_q, errSum_q, contArm_q;
  logic [4:0] preCnt_q;
  logic [7:0] rateCnt_q;
  logic clkPinPrev_q, sclk_q, txd_q, txPar_q, rxPrev_q, rxParBit_q, rxStopBad_q;
  ssu_tx_state_t txState_q;
  ssu_rx_state_t rxState_q;
  logic [3:0] txPh_q, txIdx_q, rxPh_q, rxIdx_q;
  logic [15:0] rdMux;
  logic [15:0] rdata_q;
  logic txdOut_q, txdOe_q, clkOut_q, clkOe_q, altOut_q, altOe_q, flowOut_q, flowOe_q;
  logic txIrq_q, rxIrq_q;

  // Address decode
  wire wrMode = regWr && (regAddr == OFS_MODE);
  wire wrCtrl0 = regWr && (regAddr == OFS_CTRL0);
  wire wrCtrl1 = regWr && (regAddr == OFS_CTRL1);
  wire wrRate = regWr && (regAddr == OFS_RATE);
  wire wrTx = regWr && (regAddr == OFS_TXBUF);
  wire wrClkPin = regWr && (regAddr == OFS_CLKPIN);
  wire wrStatus = regWr && (regAddr == OFS_STATUS);
  wire rdRx = regRd && (regAddr == OFS_RXBUF);

  // Mode and clock decode
  wire isSync = mode_q.mode == MODE_SYNC;
  wire isAsync = mode_q.mode == MODE_ASYNC;
  wire isOff = !isSync && !isAsync;
  wire intClk = !mode_q.extClk;
  wire [3:0] charLen = isSync ? SYNC_LEN : ssu_len(mode_q.lenSel);
  wire [3:0] charLast = 4'(charLen - 4'h1);
  wire preTick = preCnt_q == ssu_pre_last(ctrl0_q.preSel);
  wire extRise = !clkPinPrev_q && transferClockPinIn;
  // Async external clock feeds the rate divider directly; software keeps it off channel three
  wire srcTick = (isAsync && mode_q.extClk) ? extRise : preTick;
  wire rateTick = srcTick && (rateCnt_q == rate_q);

  // Synchronous clock edges: lead leaves idle level and shifts, trail returns and samples
  wire idleLvl = !ctrl0_q.clkPol;
  wire leadEv = isSync && (intClk ? (rateTick && sclk_q == idleLvl)
                : (clkPinPrev_q == idleLvl && transferClockPinIn != idleLvl));
  wire trailEv = isSync && (intClk ? (rateTick && sclk_q != idleLvl)
                 : (clkPinPrev_q != idleLvl && transferClockPinIn == idleLvl));

  // Transmit start qualification
  wire ctsOk = ctrl0_q.hsDis || ctrl0_q.hsFn || !flowCtlIn;
  wire extIdleOk = !(isSync && mode_q.extClk) || transferClockPinIn == idleLvl;
  wire haveData = !txBufEmpty_q || (isSync && contArm_q);
  wire startOk = !isOff && ctrl1_q.txEn && haveData && ctsOk && extIdleOk
                 && txState_q == TX_IDLE;
  wire [8:0] loadData = txBufEmpty_q ? DUMMY_DATA : txBuf_q;
  wire [7:0] syncLoad = ctrl0_q.msbFirst ? ssu_rev8(loadData[7:0]) : loadData[7:0];
  wire txLoadEv = startOk && !txBufEmpty_q;
  wire txLastStop = !(mode_q.stop2 && txIdx_q == 4'h0);
  wire txEndEv = (txState_q == TX_DATA && trailEv && txIdx_q == SYNC_LAST)
                 || (txState_q == TX_STOP && rateTick && txPh_q == OVS_LAST && txLastStop);

  // Receive delivery
  wire [8:0] syncShift = {serialDataInPin, rxShift_q[8:1]};
  wire syncRxDone = txState_q == TX_DATA && trailEv && txIdx_q == SYNC_LAST && ctrl1_q.rxEn;
  wire rxLastStop = !(mode_q.stop2 && rxIdx_q == 4'h0);
  wire asyncDone = rxState_q == RX_STOP && rateTick && rxPh_q == OVS_LAST && rxLastStop;
  wire deliverEv = syncRxDone || asyncDone;
  wire [8:0] rxRaw = ssu_align(isSync ? syncShift : rxShift_q, charLen);
  wire [8:0] rxChar = (isSync && ctrl0_q.msbFirst) ? {1'b0, ssu_rev8(rxRaw[7:0])} : rxRaw;
  wire ovrHit = deliverEv && rxFull_q && !rdRx;
  wire ovr_d = ovrHit || (ovr_q && !(wrStatus && regWdata[ST_OVR]));
  wire fer_d = (asyncDone && (rxStopBad_q || !serialDataInPin))
               || (fer_q && !(wrStatus && regWdata[ST_FER]));
  wire per_d = (asyncDone && mode_q.parEn
               && rxParBit_q != ssu_parity(rxChar, charLen, mode_q.parOdd))
               || (per_q && !(wrStatus && regWdata[ST_PER]));

  // Software registers; reserved bits are never stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_q <= REG_RST;
      ctrl0_q <= REG_RST;
      ctrl1_q <= REG_RST;
      clkPin_q <= 2'h0;
      rate_q <= RATE_RST;
    end else begin
      if (wrMode) mode_q <= regWdata & 16'h03fb;
      if (wrCtrl0) ctrl0_q <= regWdata & 16'h00d7;
      if (wrCtrl1) ctrl1_q <= regWdata & 16'h0075;
      if (wrClkPin) clkPin_q <= regWdata[5:4];
      if (wrRate) rate_q <= regWdata[7:0];
    end
  end

  // Transmit buffer; a write in the load cycle keeps the new data pending
  always_ff @(posedge mclk) begin
    if (reset) begin
      txBuf_q <= 9'h000;
      txBufEmpty_q <= 1'b1;
      contArm_q <= 1'b0;
    end else begin
      if (wrTx) txBuf_q <= ctrl1_q.invData ? ~regWdata[8:0] : regWdata[8:0];
      if (wrTx) txBufEmpty_q <= 1'b0;
      else if (txLoadEv) txBufEmpty_q <= 1'b1;
      if (rdRx && ctrl1_q.contRx && isSync) contArm_q <= 1'b1;
      else if (startOk) contArm_q <= 1'b0;
    end
  end

  // Prescaler, rate divider and pin history
  always_ff @(posedge mclk) begin
    if (reset) begin
      preCnt_q <= 5'h00;
      rateCnt_q <= 8'h00;
      clkPinPrev_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      preCnt_q <= preTick ? 5'h00 : 5'(preCnt_q + 5'h01);
      if (isOff) rateCnt_q <= 8'h00;
      else if (srcTick) rateCnt_q <= rateTick ? 8'h00 : 8'(rateCnt_q + 8'h01);
      clkPinPrev_q <= transferClockPinIn;
      rxPrev_q <= serialDataInPin;
    end
  end

  // Internal synchronous clock runs only during a transfer
  always_ff @(posedge mclk) begin
    if (reset) sclk_q <= 1'b1;
    else if (!(isSync && txState_q == TX_DATA)) sclk_q <= idleLvl;
    else if (rateTick && intClk) sclk_q <= !sclk_q;
  end

  // Transmit engine; synchronous mode uses the data state only
  always_ff @(posedge mclk) begin
    if (reset || isOff) begin
      txState_q <= TX_IDLE;
      txd_q <= 1'b1;
      txShift_q <= 9'h000;
      txPh_q <= 4'h0;
      txIdx_q <= 4'h0;
      txPar_q <= 1'b0;
    end else begin
      case (txState_q)
        TX_IDLE: begin
          txd_q <= 1'b1;
          txPh_q <= 4'h0;
          txIdx_q <= 4'h0;
          if (startOk) begin
            txPar_q <= ssu_parity(loadData, charLen, mode_q.parOdd);
            if (isSync) begin
              txShift_q <= {1'b0, syncLoad};
              txd_q <= syncLoad[0];
              txState_q <= TX_DATA;
            end else begin
              txShift_q <= loadData;
              txd_q <= 1'b0;
              txState_q <= TX_START;
            end
          end
        end
        TX_START: if (rateTick) begin
          txPh_q <= 4'(txPh_q + 4'h1);
          if (txPh_q == OVS_LAST) begin
            txd_q <= txShift_q[0];
            txState_q <= TX_DATA;
          end
        end
        TX_DATA: if (isSync) begin
          if (leadEv && txIdx_q != 4'h0) begin
            txShift_q <= txShift_q >> 1;
            txd_q <= txShift_q[1];
          end
          if (trailEv) begin
            txIdx_q <= 4'(txIdx_q + 4'h1);
            if (txIdx_q == SYNC_LAST) txState_q <= TX_IDLE;
          end
        end else if (rateTick) begin
          txPh_q <= 4'(txPh_q + 4'h1);
          if (txPh_q == OVS_LAST) begin
            if (txIdx_q == charLast) begin
              txIdx_q <= 4'h0;
              txd_q <= mode_q.parEn ? txPar_q : 1'b1;
              txState_q <= mode_q.parEn ? TX_PAR : TX_STOP;
            end else begin
              txShift_q <= txShift_q >> 1;
              txd_q <= txShift_q[1];
              txIdx_q <= 4'(txIdx_q + 4'h1);
            end
          end
        end
        TX_PAR: if (rateTick) begin
          txPh_q <= 4'(txPh_q + 4'h1);
          if (txPh_q == OVS_LAST) begin
            txd_q <= 1'b1;
            txState_q <= TX_STOP;
          end
        end
        TX_STOP: if (rateTick) begin
          txPh_q <= 4'(txPh_q + 4'h1);
          if (txPh_q == OVS_LAST) begin
            if (txLastStop) txState_q <= TX_IDLE;
            else txIdx_q <= 4'h1;
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // Asynchronous receiver plus the synchronous sample shift
  always_ff @(posedge mclk) begin
    if (reset || !isAsync) begin
      rxState_q <= RX_IDLE;
      rxPh_q <= 4'h0;
      rxIdx_q <= 4'h0;
      rxParBit_q <= 1'b0;
      rxStopBad_q <= 1'b0;
      if (reset) rxShift_q <= 9'h000;
      else if (txState_q == TX_DATA && trailEv) rxShift_q <= syncShift;
    end else begin
      case (rxState_q)
        RX_IDLE: if (ctrl1_q.rxEn && rxPrev_q && !serialDataInPin) begin
          rxState_q <= RX_START;
          rxPh_q <= 4'h0;
          rxIdx_q <= 4'h0;
          rxStopBad_q <= 1'b0;
        end
        RX_START: if (rateTick) begin
          rxPh_q <= 4'(rxPh_q + 4'h1);
          if (rxPh_q == OVS_MID) begin
            rxPh_q <= 4'h0;
            rxState_q <= serialDataInPin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (rateTick) begin
          rxPh_q <= 4'(rxPh_q + 4'h1);
          if (rxPh_q == OVS_LAST) begin
            rxShift_q <= syncShift;
            rxIdx_q <= 4'(rxIdx_q + 4'h1);
            if (rxIdx_q == charLast) begin
              rxIdx_q <= 4'h0;
              rxState_q <= mode_q.parEn ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: if (rateTick) begin
          rxPh_q <= 4'(rxPh_q + 4'h1);
          if (rxPh_q == OVS_LAST) begin
            rxParBit_q <= serialDataInPin;
            rxState_q <= RX_STOP;
          end
        end
        RX_STOP: if (rateTick) begin
          rxPh_q <= 4'(rxPh_q + 4'h1);
          if (rxPh_q == OVS_LAST) begin
            if (!serialDataInPin) rxStopBad_q <= 1'b1;
            if (rxLastStop) rxState_q <= RX_IDLE;
            else rxIdx_q <= 4'h1;
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer and flags; hardware sets win over software clears
  always_ff @(posedge mclk) begin
    if (reset) begin
      rxBuf_q <= 9'h000;
      rxFull_q <= 1'b0;
      {ovr_q, fer_q, per_q, errSum_q} <= 4'h0;
      rxIrq_q <= 1'b0;
      txIrq_q <= 1'b0;
      txDone_q <= 1'b1;
    end else begin
      if (deliverEv) rxBuf_q <= rxChar;
      if (deliverEv) rxFull_q <= 1'b1;
      else if (rdRx) rxFull_q <= 1'b0;
      ovr_q <= ovr_d;
      fer_q <= fer_d;
      per_q <= per_d;
      errSum_q <= ovr_d || fer_d || per_d;
      rxIrq_q <= deliverEv && !ovrHit;
      txIrq_q <= ctrl1_q.txCause ? txEndEv : txLoadEv;
      if (txEndEv) txDone_q <= 1'b1;
      else if (startOk) txDone_q <= 1'b0;
    end
  end

  // Read mux; unmapped and write-only offsets read zero
  always_comb begin
    if (regAddr == OFS_MODE) rdMux = mode_q;
    else if (regAddr == OFS_CTRL0) rdMux = ctrl0_q;
    else if (regAddr == OFS_CTRL1)
      rdMux = ctrl1_q | ({15'h0, txBufEmpty_q} << C1_TBEMPTY) | ({15'h0, txDone_q} << C1_TXDONE);
    else if (regAddr == OFS_RATE) rdMux = {8'h00, rate_q};
    else if (regAddr == OFS_RXBUF) rdMux = {7'h00, ctrl1_q.invData ? ~rxBuf_q : rxBuf_q};
    else if (regAddr == OFS_CLKPIN) rdMux = {10'h000, clkPin_q, 4'h0};
    else if (regAddr == OFS_STATUS) rdMux = {11'h000, rxFull_q, errSum_q, per_q, fer_q, ovr_q};
    else rdMux = 16'h0000;
  end

  // Pin drivers, all registered
  wire useAlt = HAS_ALT_CLK && clkPin_q == CLKPIN_ALT;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
      {txdOut_q, txdOe_q, clkOut_q, clkOe_q} <= 4'ha; // Clock pin out rests at its idle high
      {altOut_q, altOe_q, flowOut_q, flowOe_q} <= 4'ha;
    end else begin
      rdata_q <= regRd ? rdMux : 16'h0000;
      txdOut_q <= txd_q;
      txdOe_q <= !isOff && (!mode_q.openDrain || !txd_q);
      clkOut_q <= sclk_q;
      clkOe_q <= isSync && intClk && !useAlt;
      altOut_q <= sclk_q;
      altOe_q <= isSync && intClk && useAlt;
      flowOut_q <= !(ctrl1_q.rxEn && !rxFull_q);
      flowOe_q <= !ctrl0_q.hsDis && ctrl0_q.hsFn;
    end
  end

  assign regRdata = rdata_q;
  assign serialDataOutPin = txdOut_q;
  assign serialDataOutOe = txdOe_q;
  assign transferClockPinOut = clkOut_q;
  assign transferClockPinOe = clkOe_q;
  assign alternateClockOutPin = altOut_q;
  assign alternateClockOutOe = altOe_q;
  assign flowCtlOut = flowOut_q;
  assign flowCtlOe = flowOe_q;
  assign txIrqPulse = txIrq_q;
  assign rxIrqPulse = rxIrq_q;

  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_leaveIdle; txState_q == TX_IDLE ##1 txState_q == TX_START; endsequence
  sequence s_rxBegin; rxState_q == RX_IDLE ##1 rxState_q == RX_START; endsequence
  property p_idleHigh; (txState_q == TX_IDLE) [*2] |-> txd_q; endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("data out not high while idle");
  property p_clkOut; isSync && intClk && !useAlt |=> transferClockPinOe; endproperty
  a_clkOut: assert property (p_clkOut) else $error("clock pin not driven");
  property p_flowPort; ctrl0_q.hsDis |=> !flowCtlOe; endproperty
  a_flowPort: assert property (p_flowPort) else $error("flow pin driven when disabled");
  property p_invWrite; wrTx && ctrl1_q.invData |=> txBuf_q == ~9'($past(regWdata)); endproperty
  a_invWrite: assert property (p_invWrite) else $error("transmit data not inverted");
  property p_txStart; s_leaveIdle |-> $past(ctrl1_q.txEn && !txBufEmpty_q && ctsOk); endproperty
  a_txStart: assert property (p_txStart) else $error("transmit began without conditions");
  property p_rxStart; s_rxBegin |-> $past(ctrl1_q.rxEn && !serialDataInPin); endproperty
  a_rxStart: assert property (p_rxStart) else $error("reception began without start bit");
  // A buffer write in the load cycle keeps the buffer full, so leave that case out
  property p_txIrqLoad;
    txLoadEv && !wrTx && !ctrl1_q.txCause |=> txIrqPulse && txBufEmpty_q;
  endproperty
  a_txIrqLoad: assert property (p_txIrqLoad) else $error("no transmit request at load");
  property p_rxIrq; deliverEv && !ovrHit |=> rxIrqPulse && rxFull_q ##1 !rxIrqPulse; endproperty
  a_rxIrq: assert property (p_rxIrq) else $error("receive request wrong");
  property p_overrun; ovrHit |=> ovr_q && !rxIrqPulse && errSum_q; endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");
  property p_errSum; (ovr_q || fer_q || per_q) |-> errSum_q; endproperty
  a_errSum: assert property (p_errSum) else $error("error sum flag clear");
endmodule // ssu_serial_unit
`default_nettype wire

// *** verification/ssu_peer_model.sv ***
// Serial peer model: loops the data line back, and can stall or break it
`timescale 1ns/1ps
`default_nettype none
module ssu_peer_model (
  // Line from the unit
  input wire logic txPin,
  input wire logic txOe,
  // Commands from the bench
  input wire logic peerBusy,
  input wire logic holdLow,
  // Lines to the unit
  output logic rxLine,
  output logic ctsLevel
);
  // A released line is pulled up, so an undriven pin reads high, never a stale value
  assign rxLine = holdLow ? 1'b0 : (txOe ? txPin : 1'b1);
  // A busy peer holds clear-to-send high, which must stall the sender
  assign ctsLevel = peerBusy;
endmodule // ssu_peer_model
`default_nettype wire

// *** verification/ssu_serial_unit_tb.sv ***
// Self-checking bench for the serial unit in asynchronous and synchronous loopback
`timescale 1ns/1ps
`default_nettype none
module ssu_serial_unit_tb import ssu_pkg::*;;
  typedef struct packed {logic [15:0] mode; logic [15:0] data; logic [15:0] exp;} ssu_row_t;
  logic mclk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic peerBusy = 1'b0, holdLow = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [15:0] regWdata = 16'h0000, regRdata, got;
  logic serialDataOutPin, serialDataOutOe, rxLine, ctsLevel, txIrqPulse, rxIrqPulse, clkOe;
  int mismatches = 0, checks = 0, rxCnt = 0, txCnt = 0, n, m;
  // Frame formats: 7 bits, 8 even, 9 odd with two stops, 8 odd with zero data
  ssu_row_t rows [4] = '{'{16'h0002, 16'h00ff, 16'h007f}, '{16'h0092, 16'h00a5, 16'h00a5},
                         '{16'h01e2, 16'h0155, 16'h0155}, '{16'h0192, 16'h0000, 16'h0000}};

  always #50 mclk = ~mclk;

  // Request pulses last one cycle, so count them on every edge
  always @(posedge mclk) begin
    if (rxIrqPulse === 1'b1) rxCnt <= rxCnt + 1;
    if (txIrqPulse === 1'b1) txCnt <= txCnt + 1;
  end

  ssu_serial_unit dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .serialDataInPin(rxLine),
    .serialDataOutPin(serialDataOutPin), .serialDataOutOe(serialDataOutOe),
    .transferClockPinIn(1'b1), .transferClockPinOut(), .transferClockPinOe(clkOe),
    .alternateClockOutPin(), .alternateClockOutOe(), .flowCtlIn(ctsLevel), .flowCtlOut(),
    .flowCtlOe(), .txIrqPulse(txIrqPulse), .rxIrqPulse(rxIrqPulse));

  ssu_peer_model peer (.txPin(serialDataOutPin), .txOe(serialDataOutOe), .peerBusy(peerBusy),
    .holdLow(holdLow), .rxLine(rxLine), .ctsLevel(ctsLevel));

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    got = regRdata;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string msg);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask

  // Bounded wait for the transmit or receive count to pass a mark
  task automatic waitIrq(input bit tx, input int c);
    int i;
    for (i = 0; i < 400 && (tx ? txCnt : rxCnt) <= c; i++) @(posedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (9) @(posedge mclk);
    chk({15'h0000, serialDataOutOe}, 16'h0000, "oe in reset");
    @(posedge mclk);
    reset <= 1'b0;
    rd(OFS_CTRL1);
    chk(got, 16'h000a, "ctrl1 reset value");
    wr(OFS_RATE, 16'h0000);
    wr(OFS_CTRL1, 16'h0005);
    // Loopback rows with transmit request at load time
    foreach (rows[k]) begin
      wr(OFS_MODE, rows[k].mode);
      repeat (3) @(posedge mclk);
      chk({15'h0000, serialDataOutPin & serialDataOutOe}, 16'h0001, "idle high");
      n = rxCnt;
      m = txCnt;
      wr(OFS_TXBUF, rows[k].data);
      waitIrq(1'b1, m);
      chk(16'(rxCnt - n), 16'h0000, "tx request at load");
      waitIrq(1'b0, n);
      rd(OFS_RXBUF);
      chk(got, rows[k].exp, "rx data");
      rd(OFS_STATUS);
      chk(got, 16'h0000, "no errors");
    end
    $display("test rows done");
    // Clear-to-send high must hold the frame back
    wr(OFS_MODE, 16'h0012);
    peerBusy <= 1'b1;
    n = rxCnt;
    m = txCnt;
    wr(OFS_TXBUF, 16'h003c);
    repeat (60) @(posedge mclk);
    rd(OFS_CTRL1);
    chk(got & 16'h0002, 16'h0000, "buffer still full");
    chk(16'(txCnt - m), 16'h0000, "no load while busy");
    @(posedge mclk);
    peerBusy <= 1'b0;
    waitIrq(1'b0, n);
    rd(OFS_RXBUF);
    chk(got, 16'h003c, "data after stall");
    $display("test stall done");
    // Second frame unread: overrun, overwrite, no new receive request
    wr(OFS_CTRL1, 16'h0015);
    n = rxCnt;
    m = txCnt;
    wr(OFS_TXBUF, 16'h0011);
    waitIrq(1'b1, m);
    chk(16'(rxCnt - n), 16'h0001, "tx request at end");
    m = txCnt;
    wr(OFS_TXBUF, 16'h0022);
    waitIrq(1'b1, m);
    repeat (20) @(posedge mclk);
    chk(16'(rxCnt - n), 16'h0001, "no request on overrun");
    rd(OFS_RXBUF);
    chk(got, 16'h0022, "buffer overwritten");
    rd(OFS_STATUS);
    chk(got, 16'h0009, "overrun and sum");
    wr(OFS_STATUS, 16'h0007);
    $display("test overrun done");
    // Line held low through the stop bit gives a framing error
    @(posedge mclk);
    holdLow <= 1'b1;
    repeat (156) @(posedge mclk);
    holdLow <= 1'b0;
    repeat (40) @(posedge mclk);
    rd(OFS_STATUS);
    chk(got & 16'h000e, 16'h000a, "framing and sum");
    $display("test framing done");
    // Synchronous loopback MSB first; the unread framing frame is drained first
    rd(OFS_RXBUF);
    wr(OFS_RATE, 16'h0001);
    wr(OFS_CTRL0, 16'h0080);
    wr(OFS_CTRL1, 16'h0025);
    wr(OFS_MODE, 16'h0001);
    n = rxCnt;
    wr(OFS_TXBUF, 16'h0086);
    repeat (3) @(posedge mclk);
    chk({14'h0000, serialDataOutPin, clkOe}, 16'h0003, "msb first, clock out");
    waitIrq(1'b0, n);
    n = rxCnt;
    rd(OFS_RXBUF);
    chk(got, 16'h0086, "sync data");
    // The read re-arms reception, so dummy ones come back with no buffer write
    waitIrq(1'b0, n);
    rd(OFS_RXBUF);
    chk(got, 16'h00ff, "dummy after re-arm");
    $display("test sync done");
    summarize();
  end

  // Watchdog well beyond the expected run of about 1700 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    summarize();
  end
endmodule // ssu_serial_unit_tb
`default_nettype wire
